// File: hw/avibar_regs.sv
/*
  Register bank for received auxiliary-video infoframe bar fields, the
  pixel repetition count and the packet change flags with interrupt.
  Assumes the packet decoder presents field values with a one-cycle load
  strobe and raises one-cycle change pulses, all on clk_sys.
  Assumes the register master holds address and strobe for one cycle
  only, never raises both strobes at once, and takes read data in the
  cycle right after its read strobe; the bank never stalls the master.
  The bar and repetition values are read-only to software: the decoder
  is their only writer. The change flags are cleared by reading any of
  their mirrored locations; a separate interrupt status, enable and
  clear set lives in free space above the bank.
*/
`default_nettype none
// Overview of operation
// - Pixel repetition zero means sent once.
// - Repetition code is sends minus one; 10-15 reserved.
// - Top bar end line; zero means none.
// - Top bar value 16 bits at 0x86/0x88.
// - Bottom bar start line at 0x89/0x8A.
// - Left bar end pixel at 0x8B/0x8C.
// - Right bar start pixel at 0x8D/0x8E.
// - Set flag when packet contents change.
// - Any flag read returns flags then clears all.
// - All flag locations mirror identical contents.
// - Flag bits AVI, audio, SPD, MPEG, ACP, ISRC1, ISRC2.
module avibar_regs (
  input wire logic clk_sys,
  input wire logic reset_n,
  // Register port.
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  // Decoder side: fields with a load strobe.
  input wire logic fld_load,
  input wire logic [3:0] fld_pixel_repetition_count,
  input wire logic [15:0] fld_top_bar_end_line,
  input wire logic [15:0] fld_bottom_bar_start_line,
  input wire logic [15:0] fld_left_bar_end_pixel,
  input wire logic [15:0] fld_right_bar_start_pixel,
  // One pulse per packet type whose contents differed from before.
  input wire logic [6:0] packet_changed,
  // Level interrupt.
  output logic irq
);

  // Held field values. They keep the last packet's contents until the
  // decoder loads a newer packet, so software may read the two halves of
  // a bar value at leisure as long as no load falls between the reads.
  logic [3:0] pixel_repetition_count;
  logic [15:0] top_bar;
  logic [15:0] bottom_bar;
  logic [15:0] left_bar;
  logic [15:0] right_bar;
  logic [3:0] next_pixel_repetition_count;
  logic [15:0] next_top_bar;
  logic [15:0] next_bottom_bar;
  logic [15:0] next_left_bar;
  logic [15:0] next_right_bar;

  // Change flags, interrupt status and enable. The flags and the status
  // are set by the same pulses but cleared apart: a flag read must not
  // drop a pending interrupt that the handler has not yet seen.
  logic [6:0] packet_change_flag;
  logic [6:0] next_packet_change_flag;
  logic [6:0] irq_status;
  logic [6:0] next_irq_status;
  logic [6:0] irq_enable;
  logic [6:0] next_irq_enable;
  logic [7:0] next_rdata;
  logic next_irq;

  // True when the address is one of the mirrored flag locations.
  function automatic logic is_flag_addr(input logic [7:0] a);
    is_flag_addr = (a == avibar_pkg::OFF_FLAGS_A) ||
                   (a == avibar_pkg::OFF_FLAGS_B) ||
                   (a == avibar_pkg::OFF_FLAGS_C);
  endfunction

  // Clamp reserved repetition codes down to the largest legal one, so
  // software never sees a reserved code from a corrupt packet.
  function automatic logic [3:0] clamp_pr(input logic [3:0] v);
    if (v > avibar_pkg::PR_MAX_LEGAL)
    begin
      clamp_pr = avibar_pkg::PR_MAX_LEGAL;
    end
    else
    begin
      clamp_pr = v;
    end
  endfunction

  // High in the cycle in which software reads any flag copy; it drives
  // the shared clear, so all copies empty together.
  logic flag_read;
  assign flag_read = rd && is_flag_addr(addr);

  // Field loads; software writes never reach these.
  // All five fields load on one strobe, so a read never sees a mix of an
  // old and a new packet between two of the fields.
  always_comb
  begin
    next_pixel_repetition_count = pixel_repetition_count;
    next_top_bar = top_bar;
    next_bottom_bar = bottom_bar;
    next_left_bar = left_bar;
    next_right_bar = right_bar;
    if (fld_load)
    begin
      next_pixel_repetition_count = clamp_pr(fld_pixel_repetition_count);
      next_top_bar = fld_top_bar_end_line;
      next_bottom_bar = fld_bottom_bar_start_line;
      next_left_bar = fld_left_bar_end_pixel;
      next_right_bar = fld_right_bar_start_pixel;
    end
  end

  // Flag and interrupt next state. New changes win over the read clear,
  // so a change that lands in the reading cycle is kept for next read.
  always_comb
  begin
    next_packet_change_flag = packet_change_flag;
    if (flag_read)
    begin
      next_packet_change_flag = avibar_pkg::FLAGS_RESET;
    end
    next_packet_change_flag = next_packet_change_flag | packet_changed;
    // Interrupt status: write one to clear, and a new pulse in the same
    // cycle sets its bit again, so no event is ever lost.
    next_irq_status = irq_status;
    if (wr && addr == avibar_pkg::OFF_IRQ_CLEAR)
    begin
      next_irq_status = irq_status & ~wdata[6:0];
    end
    next_irq_status = next_irq_status | packet_changed;
    // Enable register: plain read-write, seven bits like the flags.
    next_irq_enable = irq_enable;
    if (wr && addr == avibar_pkg::OFF_IRQ_ENABLE)
    begin
      next_irq_enable = wdata[6:0];
    end
    // The output is taken from the next values so that the registered
    // line follows the status in the same cycle, not one cycle late.
    next_irq = |(next_irq_status & next_irq_enable);
  end

  // Read data mux; any other address, and all writes, do nothing here.
  // The byte returns to zero after every read cycle, so a master that
  // samples late sees zero rather than a stale byte.
  always_comb
  begin
    next_rdata = avibar_pkg::RDATA_RESET;
    if (rd)
    begin
      if (is_flag_addr(addr))
      begin
        next_rdata = {1'b0, packet_change_flag};
      end
      else
      begin
        unique case (addr)
          avibar_pkg::OFF_PIXEL_REPEAT:
            next_rdata = {4'h0, pixel_repetition_count};
          avibar_pkg::OFF_TOP_LO: next_rdata = top_bar[7:0];
          avibar_pkg::OFF_TOP_HI: next_rdata = top_bar[15:8];
          avibar_pkg::OFF_BOT_LO: next_rdata = bottom_bar[7:0];
          avibar_pkg::OFF_BOT_HI: next_rdata = bottom_bar[15:8];
          avibar_pkg::OFF_LEFT_LO: next_rdata = left_bar[7:0];
          avibar_pkg::OFF_LEFT_HI: next_rdata = left_bar[15:8];
          avibar_pkg::OFF_RIGHT_LO: next_rdata = right_bar[7:0];
          avibar_pkg::OFF_RIGHT_HI: next_rdata = right_bar[15:8];
          avibar_pkg::OFF_IRQ_STATUS: next_rdata = {1'b0, irq_status};
          avibar_pkg::OFF_IRQ_ENABLE: next_rdata = {1'b0, irq_enable};
          default: next_rdata = avibar_pkg::RDATA_RESET;
        endcase
      end
    end
  end

  // All state registers.
  // The reset branch loads constants only; every next value comes from
  // the combinational processes above.
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      pixel_repetition_count <= avibar_pkg::PR_RESET;
      top_bar <= avibar_pkg::BAR_RESET;
      bottom_bar <= avibar_pkg::BAR_RESET;
      left_bar <= avibar_pkg::BAR_RESET;
      right_bar <= avibar_pkg::BAR_RESET;
      packet_change_flag <= avibar_pkg::FLAGS_RESET;
      irq_status <= avibar_pkg::FLAGS_RESET;
      irq_enable <= avibar_pkg::FLAGS_RESET;
      rdata <= avibar_pkg::RDATA_RESET;
      irq <= 1'b0;
    end
    else
    begin
      pixel_repetition_count <= next_pixel_repetition_count;
      top_bar <= next_top_bar;
      bottom_bar <= next_bottom_bar;
      left_bar <= next_left_bar;
      right_bar <= next_right_bar;
      packet_change_flag <= next_packet_change_flag;
      irq_status <= next_irq_status;
      irq_enable <= next_irq_enable;
      rdata <= next_rdata;
      irq <= next_irq;
    end
  end

  // Checks on the behaviour above.
  // Change flags: set, hold, clear and read back.

  // Reading a flag copy clears every copy when no change lands.
  a_flag_read_clear: assert property (@(posedge clk_sys) disable iff (!reset_n)
    flag_read && packet_changed == 7'h00 |=> packet_change_flag == 7'h00)
    else $error("flags not cleared by read");

  // Every change pulse leaves its bit set, even in a reading cycle.
  a_flag_set_change: assert property (@(posedge clk_sys) disable iff (!reset_n)
    packet_changed != 7'h00 |=> (packet_change_flag & $past(packet_changed))
      == $past(packet_changed))
    else $error("change did not set flag");

  // With no change and no read the flags keep their contents.
  a_flag_hold: assert property (@(posedge clk_sys) disable iff (!reset_n)
    !flag_read && packet_changed == 7'h00 |=> $stable(packet_change_flag))
    else $error("flags moved without cause");

  // Any copy returns the flags as they stood before the clear.
  a_flag_read_data: assert property (@(posedge clk_sys) disable iff (!reset_n)
    flag_read |=> rdata == {1'b0, $past(packet_change_flag)})
    else $error("flag read data wrong");

  // The second copy in particular mirrors the same contents.
  a_flag_mirror_b: assert property (@(posedge clk_sys) disable iff (!reset_n)
    rd && addr == avibar_pkg::OFF_FLAGS_B |=>
      rdata == {1'b0, $past(packet_change_flag)})
    else $error("second flag copy differs");

  // The unused top bit of a flag byte always reads zero.
  a_flag_msb_zero: assert property (@(posedge clk_sys) disable iff (!reset_n)
    $past(flag_read) |-> rdata[7] == 1'b0)
    else $error("flag msb not zero");

  // A lone AVI change lands in bit zero.
  a_avi_bit_pos: assert property (@(posedge clk_sys) disable iff (!reset_n)
    packet_changed == 7'h01 |=> packet_change_flag[0])
    else $error("avi flag position wrong");

  // A lone second-ISRC change lands in bit six.
  a_isrc2_bit_pos: assert property (@(posedge clk_sys) disable iff (!reset_n)
    packet_changed == 7'h40 |=> packet_change_flag[6])
    else $error("isrc2 flag position wrong");

  // Pixel repetition code: stored, clamped and read back.

  // The stored code never holds a reserved value.
  a_pr_legal_code: assert property (@(posedge clk_sys) disable iff (!reset_n)
    pixel_repetition_count <= avibar_pkg::PR_MAX_LEGAL)
    else $error("reserved repetition code");

  // A code of zero, one send, survives the load unchanged.
  a_pr_zero_once: assert property (@(posedge clk_sys) disable iff (!reset_n)
    fld_load && fld_pixel_repetition_count == 4'h0 |=>
      pixel_repetition_count == 4'h0)
    else $error("repetition zero lost");

  // Every legal code is stored as sent.
  a_pr_pass: assert property (@(posedge clk_sys) disable iff (!reset_n)
    fld_load && fld_pixel_repetition_count <= avibar_pkg::PR_MAX_LEGAL |=>
      pixel_repetition_count == $past(fld_pixel_repetition_count))
    else $error("legal repetition code altered");

  // A reserved code is stored as the largest legal one.
  a_pr_clamp: assert property (@(posedge clk_sys) disable iff (!reset_n)
    fld_load && fld_pixel_repetition_count > avibar_pkg::PR_MAX_LEGAL |=>
      pixel_repetition_count == avibar_pkg::PR_MAX_LEGAL)
    else $error("reserved repetition code kept");

  // The repetition byte carries the code in its low nibble only.
  a_pr_read: assert property (@(posedge clk_sys) disable iff (!reset_n)
    rd && addr == avibar_pkg::OFF_PIXEL_REPEAT |=>
      rdata == {4'h0, $past(pixel_repetition_count)})
    else $error("repetition read wrong");

  // Bar values: loaded by the decoder only, read as byte pairs.

  // The top bar takes the decoder's value on a load.
  a_top_load: assert property (@(posedge clk_sys) disable iff (!reset_n)
    fld_load |=> top_bar == $past(fld_top_bar_end_line))
    else $error("top bar not loaded");

  // Without a load no bar value moves, whatever software writes.
  a_bars_hold: assert property (@(posedge clk_sys) disable iff (!reset_n)
    !fld_load |=> $stable({top_bar, bottom_bar, left_bar, right_bar}))
    else $error("bar moved without load");

  a_top_low_read: assert property (@(posedge clk_sys) disable iff (!reset_n)
    rd && addr == avibar_pkg::OFF_TOP_LO |=> rdata == $past(top_bar[7:0]))
    else $error("top bar low wrong");

  a_top_high_read: assert property (@(posedge clk_sys) disable iff (!reset_n)
    rd && addr == avibar_pkg::OFF_TOP_HI |=> rdata == $past(top_bar[15:8]))
    else $error("top bar high wrong");

  a_bottom_low: assert property (@(posedge clk_sys) disable iff (!reset_n)
    rd && addr == avibar_pkg::OFF_BOT_LO |=>
      rdata == $past(bottom_bar[7:0]))
    else $error("bottom bar low wrong");

  a_bottom_high: assert property (@(posedge clk_sys) disable iff (!reset_n)
    rd && addr == avibar_pkg::OFF_BOT_HI |=>
      rdata == $past(bottom_bar[15:8]))
    else $error("bottom bar high wrong");

  // The left bar takes the decoder's value on a load.
  a_left_load: assert property (@(posedge clk_sys) disable iff (!reset_n)
    fld_load |=> left_bar == $past(fld_left_bar_end_pixel))
    else $error("left bar not loaded");

  a_left_low: assert property (@(posedge clk_sys) disable iff (!reset_n)
    rd && addr == avibar_pkg::OFF_LEFT_LO |=>
      rdata == $past(left_bar[7:0]))
    else $error("left bar low wrong");

  a_left_high: assert property (@(posedge clk_sys) disable iff (!reset_n)
    rd && addr == avibar_pkg::OFF_LEFT_HI |=>
      rdata == $past(left_bar[15:8]))
    else $error("left bar high wrong");

  a_right_read: assert property (@(posedge clk_sys) disable iff (!reset_n)
    rd && addr == avibar_pkg::OFF_RIGHT_LO |=>
      rdata == $past(right_bar[7:0]))
    else $error("right bar low wrong");

  a_right_high: assert property (@(posedge clk_sys) disable iff (!reset_n)
    rd && addr == avibar_pkg::OFF_RIGHT_HI |=>
      rdata == $past(right_bar[15:8]))
    else $error("right bar high wrong");

  // Register port and interrupt.

  // Read data stand for one cycle only and are zero otherwise.
  a_rdata_idle: assert property (@(posedge clk_sys) disable iff (!reset_n)
    !rd |=> rdata == avibar_pkg::RDATA_RESET)
    else $error("read data not idle");

  // Every change pulse sets its interrupt status bit.
  a_status_set: assert property (@(posedge clk_sys) disable iff (!reset_n)
    packet_changed != 7'h00 |=> (irq_status & $past(packet_changed))
      == $past(packet_changed))
    else $error("change did not set status");

  // Writing ones to the clear register empties those status bits.
  a_status_clear: assert property (@(posedge clk_sys) disable iff (!reset_n)
    wr && addr == avibar_pkg::OFF_IRQ_CLEAR && packet_changed == 7'h00 |=>
      (irq_status & $past(wdata[6:0])) == 7'h00)
    else $error("status not cleared");

  // The enable register takes the written bits.
  a_enable_write: assert property (@(posedge clk_sys) disable iff (!reset_n)
    wr && addr == avibar_pkg::OFF_IRQ_ENABLE |=>
      irq_enable == $past(wdata[6:0]))
    else $error("enable not written");

  // The line is high exactly while an enabled status bit is set.
  a_irq_level: assert property (@(posedge clk_sys) disable iff (!reset_n)
    irq == |(irq_status & irq_enable))
    else $error("interrupt level wrong");

endmodule // avibar_regs
`default_nettype wire

// File: include/avibar_pkg.sv
/*
  Package for the infoframe bar and change-flag register bank.
  Holds register offsets, flag bit positions, field widths and reset values.
  Assumes a byte-wide register port addressed by the printed offsets.
*/
`default_nettype none
package avibar_pkg;
  // Byte-wide register port.
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 8;
  // Printed offsets of the bank.
  localparam logic [7:0] OFF_PIXEL_REPEAT = 8'h85;
  localparam logic [7:0] OFF_TOP_LO = 8'h86;
  localparam logic [7:0] OFF_FLAGS_A = 8'h87;
  localparam logic [7:0] OFF_TOP_HI = 8'h88;
  localparam logic [7:0] OFF_BOT_LO = 8'h89;
  localparam logic [7:0] OFF_BOT_HI = 8'h8a;
  localparam logic [7:0] OFF_LEFT_LO = 8'h8b;
  localparam logic [7:0] OFF_LEFT_HI = 8'h8c;
  localparam logic [7:0] OFF_RIGHT_LO = 8'h8d;
  localparam logic [7:0] OFF_RIGHT_HI = 8'h8e;
  localparam logic [7:0] OFF_FLAGS_B = 8'h8f;
  localparam logic [7:0] OFF_FLAGS_C = 8'h97;
  // Interrupt registers placed in free space above the bank.
  localparam logic [7:0] OFF_IRQ_STATUS = 8'hf0;
  localparam logic [7:0] OFF_IRQ_ENABLE = 8'hf1;
  localparam logic [7:0] OFF_IRQ_CLEAR = 8'hf2;
  // Flag bit positions and count.
  localparam int unsigned NUM_FLAGS = 7;
  localparam int unsigned FLAG_AVI = 0;
  localparam int unsigned FLAG_AUDIO = 1;
  localparam int unsigned FLAG_SPD = 2;
  localparam int unsigned FLAG_MPEG = 3;
  localparam int unsigned FLAG_ACP = 4;
  localparam int unsigned FLAG_ISRC1 = 5;
  localparam int unsigned FLAG_ISRC2 = 6;
  // Pixel repetition field width and largest legal code.
  localparam int unsigned PR_W = 4;
  localparam logic [3:0] PR_MAX_LEGAL = 4'h9;
  // Reset values.
  localparam logic [6:0] FLAGS_RESET = 7'h00;
  localparam logic [15:0] BAR_RESET = 16'h0000;
  localparam logic [3:0] PR_RESET = 4'h0;
  localparam logic [7:0] RDATA_RESET = 8'h00;
endpackage
`default_nettype wire

// File: tb/avi_infoframe_bar_and_change_flags_test.sv
/*
  Self-checking bench for the bar and change-flag register bank.
  Assumes the host model file is compiled first, with the package.
*/
`default_nettype none
module avi_infoframe_bar_and_change_flags_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys, reset_n, wr, rd, fld_load, irq;
  logic [7:0] addr, wdata, rdata, d;
  logic [3:0] pr;
  logic [15:0] top, bot, lft, rgt;
  logic [6:0] chg;
  logic [7:0] mir [3] = '{8'h87, 8'h8f, 8'h97};
  logic [31:0] seed = 32'hbcff_ce99;
  int failures = 0;
  int n_tests = 0;
  avibar_regs avibar_regs_i (.clk_sys(clk_sys), .reset_n(reset_n),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .fld_load(fld_load), .fld_pixel_repetition_count(pr),
    .fld_top_bar_end_line(top), .fld_bottom_bar_start_line(bot),
    .fld_left_bar_end_pixel(lft), .fld_right_bar_start_pixel(rgt),
    .packet_changed(chg), .irq(irq));
  avibar_host_model avibar_host_model_i (.clk_sys(clk_sys), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata));
  // 40 MHz system clock.
  initial
  begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  // Fibonacci-style shift register for repeatable stimulus.
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  // Expected byte; reserved repetition codes read as the largest legal one.
  function automatic logic [7:0] exp_byte(input logic [7:0] a);
    case (a)
      8'h85: return {4'h0, (pr > 4'h9) ? 4'h9 : pr};
      8'h86: return top[7:0];
      8'h88: return top[15:8];
      8'h89: return bot[7:0];
      8'h8a: return bot[15:8];
      8'h8b: return lft[7:0];
      8'h8c: return lft[15:8];
      8'h8d: return rgt[7:0];
      8'h8e: return rgt[15:8];
      default: return 8'h00;
    endcase
  endfunction
  task automatic check(string nm, logic [7:0] seen, logic [7:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      failures++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic rd_check(logic [7:0] a, logic [7:0] e);
    avibar_host_model_i.bus_read(a, d);
    check($sformatf("reg %h", a), d, e);
  endtask
  // Decoder pulses: one cycle each, as the decoder makes them.
  task automatic pulse(logic [6:0] m);
    @(posedge clk_sys);
    chg <= m;
    @(posedge clk_sys);
    chg <= 7'h00;
  endtask
  task automatic test_done;
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // A hang is cut short here and counted.
  initial
  begin
    repeat (20000) @(posedge clk_sys);
    failures++;
    test_done;
  end
  initial
  begin
    {reset_n, fld_load, pr, top, bot, lft, rgt, chg} = '0;
    repeat (5) @(posedge clk_sys);
    reset_n <= 1'b1;
    rd_check(8'h87, 8'h00);
    check("irq", {7'h0, irq}, 8'h00);
    $display("test reset done");
    // Random fields with the boundary repetition codes forced in.
    for (int i = 0; i < 6; i++)
    begin
      seed = lfsr(lfsr(seed));
      @(posedge clk_sys);
      fld_load <= 1'b1;
      pr <= (i == 0) ? 4'h0 : (i == 1) ? 4'h9 : (i == 2) ? 4'hf : seed[3:0];
      top <= (i == 0) ? 16'h0000 : seed[15:0];
      bot <= seed[31:16];
      seed = lfsr(lfsr(seed));
      lft <= seed[15:0];
      rgt <= (i == 1) ? 16'hffff : seed[31:16];
      @(posedge clk_sys);
      fld_load <= 1'b0;
      for (int a = 8'h85; a <= 8'h8e; a++)
        rd_check(a[7:0], exp_byte(a[7:0]));
    end
    $display("test fields done");
    avibar_host_model_i.bus_write(8'h86, 8'hff);
    avibar_host_model_i.bus_write(8'h87, 8'h7f);
    rd_check(8'h86, exp_byte(8'h86));
    rd_check(8'h87, 8'h00);
    // Each flag alone, read at one mirror, then gone from the next.
    for (int i = 0; i < 7; i++)
    begin
      pulse(7'h01 << i);
      rd_check(mir[i % 3], 8'h01 << i);
      rd_check(mir[(i + 1) % 3], 8'h00);
    end
    pulse(7'h7f);
    rd_check(8'h8f, 8'h7f);
    rd_check(8'h87, 8'h00);
    $display("test flags done");
    // Interrupt raised, kept past a flag read, cleared, then masked.
    // The status holds every pulse sent so far, so it is cleared first.
    avibar_host_model_i.bus_write(8'hf2, 8'h7f);
    avibar_host_model_i.bus_write(8'hf1, 8'h7f);
    pulse(7'h04);
    repeat (2) @(posedge clk_sys);
    check("irq", {7'h0, irq}, 8'h01);
    rd_check(8'hf0, 8'h04);
    rd_check(8'h87, 8'h04);
    check("irq", {7'h0, irq}, 8'h01);
    avibar_host_model_i.bus_write(8'hf2, 8'h04);
    repeat (2) @(posedge clk_sys);
    check("irq", {7'h0, irq}, 8'h00);
    avibar_host_model_i.bus_write(8'hf1, 8'h00);
    pulse(7'h02);
    repeat (2) @(posedge clk_sys);
    check("irq", {7'h0, irq}, 8'h00);
    rd_check(8'hf0, 8'h02);
    rd_check(8'hf1, 8'h00);
    rd_check(8'h80, 8'h00);
    $display("test interrupt done");
    test_done;
  end
endmodule // avi_infoframe_bar_and_change_flags_test
`default_nettype wire

// File: tb/avibar_host_model.sv
/*
  Host software model: a register master on the plain byte port.
  Assumes the bank answers a read in the cycle after the strobe.
*/
`default_nettype none
module avibar_host_model (
  input wire logic clk_sys,
  output logic [7:0] addr,
  output logic [7:0] wdata,
  output logic wr,
  output logic rd,
  input wire logic [7:0] rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  // The port idles with both strobes low.
  initial
  begin
    addr = 8'h00;
    wdata = 8'h00;
    wr = 1'b0;
    rd = 1'b0;
  end
  // One-cycle write; data is inverted afterwards so nothing stale lingers.
  task automatic bus_write(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk_sys);
    wr <= 1'b0;
    wdata <= ~d;
  endtask
  // One-cycle read; data is taken only in the cycle after the strobe.
  task automatic bus_read(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk_sys);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
endmodule // avibar_host_model
`default_nettype wire
